// ==== common/lasei_pkg.sv ====
package lasei_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int SRC_N = 8;
	// register offsets (byte-wide port, printed offsets)
	localparam logic [7:0] OFF_MASK = 8'h14;
	localparam logic [7:0] OFF_EDGE_SEL = 8'h16;
	localparam logic [7:0] OFF_STATUS = 8'h17;
	localparam logic [7:0] OFF_EVENT = 8'h19;
	localparam logic [7:0] OFF_CTRL = 8'h1C;
	// field positions
	localparam int BIT_EQ = 7;
	localparam int BIT_ACT = 6;
	localparam int BIT_DEACT = 5;
	localparam int BIT_PSYNC = 4;
	localparam int BIT_TXCLK = 3;
	localparam int BIT_DRV = 2;
	localparam int BIT_AIS = 1;
	localparam int BIT_LOS = 0;
	localparam int CTRL_AUTO_LOOP = 0;
	localparam int CTRL_LOOP_ON = 1;
	// reset values
	localparam logic [7:0] RST_EDGE_SEL = 8'h00;
	localparam logic [7:0] RST_MASK = 8'hFF;
	localparam logic [7:0] RST_STATUS = 8'h00;
	// timing
	localparam longint CLK_HZ = 250000000;
	localparam longint QUAL_SHORT_US = 40000;
	localparam longint QUAL_LONG_US = 5100000;
	localparam int QUAL_SHORT_CYC = int'((QUAL_SHORT_US * CLK_HZ) / 1000000);
	localparam int QUAL_LONG_CYC = int'((QUAL_LONG_US * CLK_HZ) / 1000000);
	localparam int TXCLK_LOSS_CYC = 70;
	localparam int QCNT_W = 32;
	// code error window: errors counted per 128 bits, below 1 per 100 means at most 1
	localparam int ERRWIN_BITS = 128;
	localparam int ERRWIN_MAX = 1;
	localparam int WCNT_W = 8;
endpackage

// ==== hw/lasei_code_qual.sv ====
`timescale 1ns/1ps
// qualifies one loopback code: present longer than qual time, error ratio held under limit
module lasei_code_qual (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// detector side
	input wire logic bit_en_i,
	input wire logic code_match_i,
	input wire logic code_err_i,
	input wire logic [lasei_pkg::QCNT_W-1:0] qual_cyc_i,
	// result
	output logic qualified_o
);
	import lasei_pkg::*;
	logic [QCNT_W-1:0] time_q;
	logic [WCNT_W-1:0] bits_q;
	logic [WCNT_W-1:0] errs_q;
	logic win_bad;
	logic win_end;
	assign win_end = bit_en_i && (bits_q == WCNT_W'(ERRWIN_BITS - 1));
	assign win_bad = (errs_q + WCNT_W'(code_err_i && bit_en_i)) > WCNT_W'(ERRWIN_MAX);

	// error ratio window
	always_ff @(posedge clk_sys_i) begin
		if (rst_i || !code_match_i || win_end) begin
			bits_q <= '0;
			errs_q <= '0;
		end else if (bit_en_i) begin
			bits_q <= bits_q + WCNT_W'(1);
			errs_q <= errs_q + WCNT_W'(code_err_i);
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i || !code_match_i || (win_end && win_bad)) begin
			time_q <= '0;
			qualified_o <= 1'b0;
		end else if (time_q > qual_cyc_i) begin
			qualified_o <= 1'b1;
		end else begin
			time_q <= time_q + QCNT_W'(1);
		end
	end
endmodule

// ==== hw/lasei_top.sv ====
`timescale 1ns/1ps
module lasei_top (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// register port
	input wire logic [lasei_pkg::ADDR_W-1:0] reg_addr_i,
	input wire logic [lasei_pkg::DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [lasei_pkg::DATA_W-1:0] reg_rdata_o,
	// detector conditions
	input wire logic eq_out_of_range_i,
	input wire logic code_bit_en_i,
	input wire logic act_code_match_i,
	input wire logic deact_code_match_i,
	input wire logic code_err_i,
	input wire logic pattern_sync_i,
	input wire logic tx_line_clock_i,
	input wire logic driver_short_i,
	input wire logic alarm_ind_i,
	input wire logic signal_loss_i,
	// outputs
	output logic remote_loop_o,
	output logic irq_o
);
	import lasei_pkg::*;

	logic [DATA_W-1:0] edge_sel_q;
	logic [DATA_W-1:0] mask_q;
	logic [DATA_W-1:0] status_q;
	logic [DATA_W-1:0] status_prev_q;
	logic [DATA_W-1:0] event_q;
	logic [DATA_W-1:0] flag_q;
	logic auto_loop_q;
	logic [DATA_W-1:0] rise;
	logic [DATA_W-1:0] fall;
	logic [DATA_W-1:0] evt_d;
	logic [DATA_W-1:0] status_d;
	logic [QCNT_W-1:0] qual_cyc;
	logic act_qual;
	logic deact_qual;
	logic txclk_prev_q;
	logic [7:0] txclk_cnt_q;
	logic txclk_lost_q;
	logic wr_edge;
	logic wr_mask;
	logic wr_ctrl;
	logic rd_flag;

	assign wr_edge = reg_wr_i && (reg_addr_i == OFF_EDGE_SEL);
	assign wr_mask = reg_wr_i && (reg_addr_i == OFF_MASK);
	assign wr_ctrl = reg_wr_i && (reg_addr_i == OFF_CTRL);
	assign rd_flag = reg_rd_i && (reg_addr_i == OFF_EVENT);

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			edge_sel_q <= RST_EDGE_SEL;
		end else if (wr_edge) begin
			edge_sel_q <= reg_wdata_i;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			mask_q <= RST_MASK;
		end else if (wr_mask) begin
			mask_q <= reg_wdata_i;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			auto_loop_q <= 1'b0;
		end else if (wr_ctrl) begin
			auto_loop_q <= reg_wdata_i[CTRL_AUTO_LOOP];
		end
	end

	assign qual_cyc = auto_loop_q ? QCNT_W'(QUAL_LONG_CYC) : QCNT_W'(QUAL_SHORT_CYC);

	lasei_code_qual u_act_qual (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.bit_en_i(code_bit_en_i),
		.code_match_i(act_code_match_i),
		.code_err_i(code_err_i),
		.qual_cyc_i(qual_cyc),
		.qualified_o(act_qual)
	);

	lasei_code_qual u_deact_qual (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.bit_en_i(code_bit_en_i),
		.code_match_i(deact_code_match_i),
		.code_err_i(code_err_i),
		.qual_cyc_i(qual_cyc),
		.qualified_o(deact_qual)
	);

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			txclk_prev_q <= 1'b0;
			txclk_cnt_q <= '0;
			txclk_lost_q <= 1'b0;
		end else begin
			txclk_prev_q <= tx_line_clock_i;
			if (tx_line_clock_i != txclk_prev_q) begin
				txclk_cnt_q <= '0;
				txclk_lost_q <= 1'b0;
			end else if (txclk_cnt_q < 8'(TXCLK_LOSS_CYC)) begin
				txclk_cnt_q <= txclk_cnt_q + 8'h01;
			end else begin
				txclk_lost_q <= 1'b1;
			end
		end
	end

	always_comb begin
		status_d = '0;
		status_d[BIT_EQ] = eq_out_of_range_i;
		status_d[BIT_ACT] = act_qual;
		status_d[BIT_DEACT] = deact_qual;
		status_d[BIT_PSYNC] = pattern_sync_i;
		status_d[BIT_TXCLK] = txclk_lost_q;
		status_d[BIT_DRV] = driver_short_i;
		status_d[BIT_AIS] = alarm_ind_i;
		status_d[BIT_LOS] = signal_loss_i;
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			status_q <= RST_STATUS;
			status_prev_q <= RST_STATUS;
		end else begin
			status_q <= status_d;
			status_prev_q <= status_q;
		end
	end

	assign rise = status_q & ~status_prev_q;
	assign fall = ~status_q & status_prev_q;
	// rising always; falling when selected; mask gate
	assign evt_d = (rise | (fall & edge_sel_q)) & ~mask_q;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			event_q <= '0;
		end else begin
			event_q <= evt_d;
		end
	end

	// sticky flags, cleared on read; new event wins over the clear
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			flag_q <= '0;
		end else if (rd_flag) begin
			flag_q <= event_q;
		end else begin
			flag_q <= flag_q | event_q;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(rd_flag ? event_q : (flag_q | event_q));
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			remote_loop_o <= 1'b0;
		end else if (rise[BIT_DEACT]) begin
			remote_loop_o <= 1'b0;
		end else if (rise[BIT_ACT]) begin
			remote_loop_o <= 1'b1;
		end
	end

	// read data one cycle after the strobe, zero otherwise
	always_ff @(posedge clk_sys_i) begin
		if (rst_i || !reg_rd_i) begin
			reg_rdata_o <= '0;
		end else begin
			unique case (reg_addr_i)
				OFF_MASK: reg_rdata_o <= mask_q;
				OFF_EDGE_SEL: reg_rdata_o <= edge_sel_q;
				OFF_STATUS: reg_rdata_o <= status_q;
				OFF_EVENT: reg_rdata_o <= flag_q;
				OFF_CTRL: begin
					reg_rdata_o <= '0;
					reg_rdata_o[CTRL_AUTO_LOOP] <= auto_loop_q;
					reg_rdata_o[CTRL_LOOP_ON] <= remote_loop_o;
				end
				default: reg_rdata_o <= '0;
			endcase
		end
	end
endmodule

// ==== verif/lasei_properties.sv ====
`timescale 1ns/1ps
module lasei_props (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// watched ports
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic eq_out_of_range_i,
	input wire logic pattern_sync_i,
	input wire logic driver_short_i,
	input wire logic tx_line_clock_i,
	input wire logic remote_loop_o,
	input wire logic irq_o
);
	logic tx_q;
	logic [7:0] idle_q;
	logic st_rd;
	logic fl_rd;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	assign st_rd = reg_rd_i && reg_addr_i == 8'h17;
	assign fl_rd = reg_rd_i && reg_addr_i == 8'h19;
	// idle count of the transmit clock, saturating so long stops stay visible
	always_ff @(posedge clk_sys_i) begin
		tx_q <= tx_line_clock_i;
		if (rst_i || tx_q != tx_line_clock_i) begin
			idle_q <= 8'h00;
		end else if (idle_q != 8'hFF) begin
			idle_q <= idle_q + 8'h01;
		end
	end
	a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
		else $error("read data not zero outside read");
	a_eq_live: assert property ($past(st_rd) && !$past(rst_i, 2)
		|-> reg_rdata_o[7] == $past(eq_out_of_range_i, 2)) else $error("equalizer bit wrong");
	a_sync_live: assert property ($past(st_rd) && !$past(rst_i, 2)
		|-> reg_rdata_o[4] == $past(pattern_sync_i, 2)) else $error("sync bit wrong");
	a_drv_live: assert property ($past(st_rd) && !$past(rst_i, 2)
		|-> reg_rdata_o[2] == $past(driver_short_i, 2)) else $error("driver bit wrong");
	a_txclk_lost: assert property ($past(st_rd) && $past(idle_q) >= 8'h5A
		|-> reg_rdata_o[3]) else $error("clock loss not shown");
	a_txclk_ok: assert property ($past(st_rd) && $past(idle_q) <= 8'h32
		|-> !reg_rdata_o[3]) else $error("clock loss shown early");
	a_irq_clear: assert property ($fell(irq_o) |-> $past(fl_rd) || $past(fl_rd, 2))
		else $error("request dropped without flag read");
	a_reset_quiet: assert property (disable iff (1'b0) rst_i
		|=> !irq_o && !remote_loop_o && reg_rdata_o == 8'h00) else $error("outputs not reset");
endmodule

bind lasei_top lasei_props u_props (.clk_sys_i, .rst_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o,
	.eq_out_of_range_i, .pattern_sync_i, .driver_short_i, .tx_line_clock_i, .remote_loop_o, .irq_o);

// ==== verif/test_line_alarm_status_edge_irq.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
	$display("wrong value at %0t: got %h want %h", $time, g, e); end end
module test_line_alarm_status_edge_irq;
	logic clk_sys_i, rst_i, wr, rd, tx, txrun, loop, irq;
	logic [7:0] addr, wd, rdo, src;
	int err_total, tests_run;
	int bits[5] = '{7, 4, 2, 1, 0};
	// code qualification needs millions of cycles, so those inputs stay quiet
	lasei_top uut (.clk_sys_i, .rst_i, .reg_addr_i(addr), .reg_wdata_i(wd),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdo), .eq_out_of_range_i(src[7]),
		.code_bit_en_i(1'b0), .act_code_match_i(1'b0), .deact_code_match_i(1'b0),
		.code_err_i(1'b0), .pattern_sync_i(src[4]), .tx_line_clock_i(tx),
		.driver_short_i(src[2]), .alarm_ind_i(src[1]), .signal_loss_i(src[0]),
		.remote_loop_o(loop), .irq_o(irq));
	initial begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		if (txrun) tx <= ~tx;
	end
	task automatic wrt(input logic [7:0] a, d);
		@(posedge clk_sys_i);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk_sys_i);
		wr <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, e);
		@(posedge clk_sys_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys_i);
		rd <= 1'b0;
		#1 `CHK(rdo, e)
	endtask
	// change one source, then leave time for status, event and flag stages
	task automatic step(input int b, input logic v);
		@(posedge clk_sys_i);
		src[b] <= v;
		repeat (5) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic t_regs;
		rdc(8'h16, 8'h00);
		rdc(8'h17, 8'h00);
		rdc(8'h14, 8'hFF);
		wrt(8'h16, 8'hA5);
		rdc(8'h16, 8'hA5);
		wrt(8'h17, 8'hFF);
		rdc(8'h17, 8'h00);
		rdc(8'h3C, 8'h00);
		wrt(8'h16, 8'h00);
		rdc(8'h1C, 8'h00);
		wrt(8'h1C, 8'h01);
		rdc(8'h1C, 8'h01);
		wrt(8'h1C, 8'h00);
		rdc(8'h1C, 8'h00);
		`CHK(loop, 1'b0)
	endtask
	task automatic t_src;
		wrt(8'h14, 8'h00);
		foreach (bits[i]) begin
			step(bits[i], 1'b1);
			`CHK(irq, 1'b1)
			rdc(8'h17, 8'h01 << bits[i]);
			rdc(8'h19, 8'h01 << bits[i]);
			repeat (2) @(posedge clk_sys_i);
			#1 `CHK(irq, 1'b0)
			rdc(8'h19, 8'h00);
			step(bits[i], 1'b0);
			rdc(8'h19, 8'h00);
			wrt(8'h16, 8'hFF);
			step(bits[i], 1'b1);
			rdc(8'h19, 8'h01 << bits[i]);
			step(bits[i], 1'b0);
			rdc(8'h19, 8'h01 << bits[i]);
			wrt(8'h16, 8'h00);
		end
	endtask
	task automatic t_mask;
		wrt(8'h14, 8'hFB);
		wrt(8'h14, 8'hFF);
		step(2, 1'b1);
		`CHK(irq, 1'b0)
		rdc(8'h19, 8'h00);
		step(2, 1'b0);
	endtask
	task automatic t_txclk;
		wrt(8'h14, 8'hF7);
		@(posedge clk_sys_i);
		txrun <= 1'b0;
		repeat (40) @(posedge clk_sys_i);
		rdc(8'h17, 8'h00);
		repeat (60) @(posedge clk_sys_i);
		rdc(8'h17, 8'h08);
		rdc(8'h19, 8'h08);
		txrun <= 1'b1;
		repeat (5) @(posedge clk_sys_i);
		rdc(8'h17, 8'h00);
	endtask
	task test_done;
		$display("mismatches %0d, checks %0d", err_total, tests_run);
		if (err_total == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		{addr, wd, src} = '0;
		{wr, rd, tx} = '0;
		txrun = 1'b1;
		rst_i = 1'b1;
		err_total = 0;
		tests_run = 0;
		repeat (10) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		t_regs;
		t_src;
		t_mask;
		t_txclk;
		test_done;
	end
	// the whole sequence needs well under a thousand cycles
	initial begin
		#40000;
		err_total++;
		test_done;
	end
endmodule
